/* hw/interrupt_vector_dispatch.sv */
/*
 * Interrupt vector dispatch: turns an accepted trap or peripheral
 * request into a vector address, fetches the four vector bytes, and
 * loads the program counter with the routine address found there.
 * Assumes the acceptance logic presents one request at a time with
 * accept high for one cycle, that memory answers a byte read with
 * mem_rvalid, and that peripheral lines are synchronous to clk.
 */
// What this block does
// - Four-byte vectors; on acceptance load PC from the matching vector.
// - Fixed area at the top; reset highest, NMI just below.
// - Undefined, overflow, break, address match, single-step in rising slots.
// - Watchdog, oscillator detect and both voltage monitors share one slot.
// - Flash variants also read the fixed high word for id check and options.
// - Break vector byte all ones redirects break to table offset zero.
// - Relocatable area is 256 bytes from the table base register.
// - Software trap numbers 0 to 63 select offset number times four.
// - Software and break traps ignore the global maskable-enable flag.
// - Relocatable addresses are base plus offset, never absolute.
// - Pins 7, 6, 3 use numbers 2, 3, 4; timer B5 uses 5.
// - Timer A0-A4 use 21-25; timer B0-B2 use 26-28.
// - Numbers 8 and 9 pick serial unit or pin by select bits 7, 6.
// - Numbers 6 and 7 pick timer B or UART event by bits 27, 26.
// - Numbers 43 and 44 pick UART5 or consumer-control by bits 33, 34.
// - Numbers 46 and 47 pick UART6 or real-time clock by bits 35, 36.
// - Numbers 49 and 50 pick UART7 or remote receiver by bits 24, 25.
// - Numbers 59 and 60 raise only when select bits 22, 23 choose them.
// - In I2C mode, NACK raises transmit and ACK raises receive vectors.
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_dispatch
    import vector_dispatch_pkg::*;
#(
    parameter bit FLASH_VARIANT = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic accept,
    input wire logic reset_fetch,
    input wire trap_req_s traps,
    input wire sysmon_req_s sysmon,
    input wire logic global_enable,
    input wire logic [19:0] vector_table_base,
    input wire source_select_s source_select,
    input wire logic [4:0] timer_a,
    input wire logic [5:0] timer_b,
    input wire logic ext_request_pin_7,
    input wire logic ext_request_pin_6,
    input wire logic ext_request_pin_5,
    input wire logic ext_request_pin_4,
    input wire logic ext_request_pin_3,
    input wire logic clocked_serial_3,
    input wire logic clocked_serial_4,
    input wire logic [7:0] uart_startstop,
    input wire logic [7:0] uart_tx,
    input wire logic [7:0] uart_rx,
    input wire logic [7:0] uart_nack,
    input wire logic [7:0] uart_ack,
    input wire logic [7:0] uart_i2c_mode,
    input wire logic [1:0] consumer_control_link,
    input wire logic [1:0] rtc_event,
    input wire logic [1:0] remote_rx,
    input wire logic i2c_iface,
    input wire logic scl_sda,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_rvalid,
    output logic mem_req,
    output logic [19:0] mem_addr,
    output logic [19:0] pc,
    output logic pc_load,
    output logic high_word_read,
    output logic [5:0] hw_vector,
    output logic hw_request,
    output logic busy
);
    // ----------------------------------------------------------------
    // Address helpers
    // ----------------------------------------------------------------
    function automatic logic [19:0] reloc_addr(input logic [19:0] base, input logic [5:0] num);
        reloc_addr = base + {12'h000, num, 2'b00};
    endfunction

    // ----------------------------------------------------------------
    // Peripheral source mapping
    // ----------------------------------------------------------------
    logic [63:0] src;
    logic [7:0] uart_t;
    logic [7:0] uart_r;
    logic [5:0] next_vector;
    logic next_hit;

    always_comb begin
        uart_t = (uart_i2c_mode & uart_nack) | (~uart_i2c_mode & uart_tx);
        uart_r = (uart_i2c_mode & uart_ack) | (~uart_i2c_mode & uart_rx);
        src = '0;
        src[VN_PIN7] = ext_request_pin_7;
        src[VN_PIN6] = ext_request_pin_6;
        src[VN_PIN3] = ext_request_pin_3;
        src[VN_TB5] = timer_b[5];
        src[VN_SHARE6] = source_select.sel_b[SEL_B_27] ? uart_startstop[1] : timer_b[4];
        src[VN_SHARE7] = source_select.sel_b[SEL_B_26] ? uart_startstop[0] : timer_b[3];
        src[VN_SHARE8] = source_select.sel_a[SEL_A_7] ? ext_request_pin_5 : clocked_serial_4;
        src[VN_SHARE9] = source_select.sel_a[SEL_A_6] ? ext_request_pin_4 : clocked_serial_3;
        src[VN_SHARE9 + 6'h01] = uart_startstop[2];
        src[VN_UART_BASE] = uart_t[2];
        src[VN_UART_BASE + 6'h01] = uart_r[2];
        src[VN_UART_BASE + 6'h02] = uart_t[0];
        src[VN_UART_BASE + 6'h03] = uart_r[0];
        src[VN_UART_BASE + 6'h04] = uart_t[1];
        src[VN_UART_BASE + 6'h05] = uart_r[1];
        for (int i = 0; i < 5; i++) begin
            src[VN_TA0 + i[5:0]] = timer_a[i];
        end
        for (int i = 0; i < 3; i++) begin
            src[VN_TB0 + i[5:0]] = timer_b[i];
        end
        src[VN_SHARE43] = source_select.sel_c[SEL_C_33] ? consumer_control_link[0] : uart_startstop[5];
        src[VN_SHARE43 + 6'h01] = source_select.sel_c[SEL_C_34] ? consumer_control_link[1] : uart_t[5];
        src[VN_SHARE43 + 6'h02] = uart_r[5];
        src[VN_SHARE46] = source_select.sel_c[SEL_C_35] ? rtc_event[0] : uart_startstop[6];
        src[VN_SHARE46 + 6'h01] = source_select.sel_c[SEL_C_36] ? rtc_event[1] : uart_t[6];
        src[VN_SHARE46 + 6'h02] = uart_r[6];
        src[VN_SHARE49] = source_select.sel_b[SEL_B_24] ? remote_rx[0] : uart_startstop[7];
        src[VN_SHARE49 + 6'h01] = source_select.sel_b[SEL_B_25] ? remote_rx[1] : uart_t[7];
        src[VN_SHARE49 + 6'h02] = uart_r[7];
        src[VN_I2C] = source_select.sel_b[SEL_B_22] & i2c_iface;
        src[VN_SCLSDA] = source_select.sel_b[SEL_B_23] & scl_sda;
        next_hit = 1'b0;
        next_vector = '0;
        // Lowest number wins here; true priority belongs to the acceptance logic.
        for (int i = 63; i >= 0; i--) begin
            if (src[i]) begin
                next_hit = 1'b1;
                next_vector = i[5:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hw_vector <= '0;
            hw_request <= 1'b0;
        end else if (clk_en) begin
            hw_vector <= next_vector;
            hw_request <= next_hit & global_enable;
        end
    end

    // ----------------------------------------------------------------
    // Vector selection
    // ----------------------------------------------------------------
    logic [19:0] next_vec_addr;
    logic next_fixed;

    always_comb begin
        next_fixed = 1'b1;
        if (reset_fetch) begin
            next_vec_addr = FIX_RESET;
        end else if (traps.nmi) begin
            next_vec_addr = FIX_NMI;
        end else if (|sysmon) begin
            next_vec_addr = FIX_SYSMON;
        end else if (traps.debug_break) begin
            next_vec_addr = FIX_DEBUG;
        end else if (traps.single_step) begin
            next_vec_addr = FIX_STEP;
        end else if (traps.addr_match) begin
            next_vec_addr = FIX_ADDR_MATCH;
        end else if (traps.break_op) begin
            next_vec_addr = FIX_BREAK;
        end else if (traps.overflow) begin
            next_vec_addr = FIX_OVFL;
        end else if (traps.undef_op) begin
            next_vec_addr = FIX_UNDEF;
        end else if (traps.sw_trap) begin
            next_fixed = 1'b0;
            next_vec_addr = reloc_addr(vector_table_base, traps.sw_num);
        end else begin
            next_fixed = 1'b0;
            next_vec_addr = reloc_addr(vector_table_base, hw_vector);
        end
    end

    // ----------------------------------------------------------------
    // Vector fetch sequence
    // ----------------------------------------------------------------
    fetch_state_e state;
    logic [1:0] byte_idx;
    logic [19:0] vec_addr;
    logic is_fixed;
    logic break_probe;
    logic [15:0] low_bytes;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= FETCH_IDLE;
            byte_idx <= '0;
            vec_addr <= '0;
            is_fixed <= 1'b0;
            break_probe <= 1'b0;
            low_bytes <= '0;
            mem_req <= 1'b0;
            mem_addr <= '0;
            pc <= '0;
            pc_load <= 1'b0;
            high_word_read <= 1'b0;
            busy <= 1'b0;
        end else if (clk_en) begin
            pc_load <= 1'b0;
            high_word_read <= 1'b0;
            case (state)
                FETCH_IDLE: begin
                    // Probe only when the break slot really won, never on a table hit at the same address.
                    if (accept && (reset_fetch || (next_fixed && next_vec_addr == FIX_BREAK))) begin
                        state <= FETCH_LOW;
                        break_probe <= !reset_fetch;
                        vec_addr <= next_vec_addr;
                        is_fixed <= 1'b1;
                        mem_req <= 1'b1;
                        mem_addr <= reset_fetch ? next_vec_addr : BREAK_PROBE;
                        byte_idx <= '0;
                        busy <= 1'b1;
                    end else if (accept) begin
                        state <= FETCH_LOW;
                        break_probe <= 1'b0;
                        vec_addr <= next_vec_addr;
                        is_fixed <= next_fixed;
                        mem_req <= 1'b1;
                        mem_addr <= next_vec_addr;
                        byte_idx <= '0;
                        busy <= 1'b1;
                    end
                end
                FETCH_LOW: begin
                    if (mem_rvalid && break_probe) begin
                        break_probe <= 1'b0;
                        if (mem_rdata == BREAK_REDIRECT) begin
                            vec_addr <= reloc_addr(vector_table_base, VN_BREAK);
                            mem_addr <= reloc_addr(vector_table_base, VN_BREAK);
                            is_fixed <= 1'b0;
                        end else begin
                            mem_addr <= vec_addr;
                        end
                    end else if (mem_rvalid) begin
                        byte_idx <= byte_idx + 2'd1;
                        mem_addr <= mem_addr + 20'h00001;
                        if (byte_idx == 2'd0) begin
                            low_bytes[7:0] <= mem_rdata;
                        end else if (byte_idx == 2'd1) begin
                            low_bytes[15:8] <= mem_rdata;
                        end else begin
                            // Upper nibble of the byte is zero by convention and is dropped.
                            pc <= {mem_rdata[3:0], low_bytes};
                            state <= FETCH_HIGH;
                        end
                    end
                end
                FETCH_HIGH: begin
                    if (mem_rvalid) begin
                        mem_req <= 1'b0;
                        pc_load <= 1'b1;
                        high_word_read <= is_fixed & FLASH_VARIANT;
                        busy <= 1'b0;
                        state <= FETCH_IDLE;
                    end
                end
                default: begin
                    state <= FETCH_IDLE;
                    mem_req <= 1'b0;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_pc_load_follows: assert property (@(posedge clk) disable iff (!rst_n)
        pc_load |-> $past(state) == FETCH_HIGH && !busy)
        else $error("pc load outside the high-word phase");
    a_reset_slot: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && accept && reset_fetch && state == FETCH_IDLE |=> mem_addr == FIX_RESET)
        else $error("reset vector address wrong");
    a_sysmon_slot: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && accept && state == FETCH_IDLE && !reset_fetch && !traps.nmi && (|sysmon)
        |=> mem_addr == FIX_SYSMON)
        else $error("shared monitor slot wrong");
    a_undef_slot: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && accept && state == FETCH_IDLE && traps == 14'h2000 && !(|sysmon) && !reset_fetch
        |=> mem_addr == FIX_UNDEF)
        else $error("undefined opcode slot wrong");
    a_swtrap_addr: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && accept && state == FETCH_IDLE && !next_fixed
        |=> mem_addr == $past(vector_table_base)
            + {12'h000, ($past(traps.sw_trap) ? $past(traps.sw_num) : $past(hw_vector)), 2'b00})
        else $error("relocatable address not base relative");
    a_sclsda_gate: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && !source_select.sel_b[SEL_B_23] |=> !(hw_request && hw_vector == VN_SCLSDA))
        else $error("scl/sda vector raised while deselected");
    a_unassigned: assert property (@(posedge clk) disable iff (!rst_n)
        hw_request |-> !(hw_vector inside {6'h00, 6'h01} || hw_vector > VN_SCLSDA))
        else $error("hardware request on unassigned number");
    a_high_word: assert property (@(posedge clk) disable iff (!rst_n)
        high_word_read |-> pc_load)
        else $error("high word flag without vector load");
endmodule
`default_nettype wire

/* shared/vector_dispatch_pkg.sv */
/*
 * Constants and carrier types for the interrupt vector dispatch block.
 * Assumes a 20-bit address space and byte-wide vector reads by the core.
 */
package vector_dispatch_pkg;
    // ----------------------------------------------------------------
    // Address layout
    // ----------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam int VEC_BYTES = 4;
    localparam int VEC_SHIFT = 2;
    localparam int TABLE_BYTES = 256;
    localparam int VEC_NUM_W = 6;
    localparam logic [19:0] FIX_UNDEF = 20'hfffdc;
    localparam logic [19:0] FIX_OVFL = 20'hfffe0;
    localparam logic [19:0] FIX_BREAK = 20'hfffe4;
    localparam logic [19:0] FIX_ADDR_MATCH = 20'hfffe8;
    localparam logic [19:0] FIX_STEP = 20'hfffec;
    localparam logic [19:0] FIX_SYSMON = 20'hffff0;
    localparam logic [19:0] FIX_DEBUG = 20'hffff4;
    localparam logic [19:0] FIX_NMI = 20'hffff8;
    localparam logic [19:0] FIX_RESET = 20'hffffc;
    localparam logic [19:0] BREAK_PROBE = 20'hfffe6;
    localparam logic [7:0] BREAK_REDIRECT = 8'hff;
    localparam logic [19:0] HIGH_WORD_OFS = 20'h00002;

    // ----------------------------------------------------------------
    // Vector numbers
    // ----------------------------------------------------------------
    localparam logic [5:0] VN_BREAK = 6'h00;
    localparam logic [5:0] VN_PIN7 = 6'h02;
    localparam logic [5:0] VN_PIN6 = 6'h03;
    localparam logic [5:0] VN_PIN3 = 6'h04;
    localparam logic [5:0] VN_TB5 = 6'h05;
    localparam logic [5:0] VN_SHARE6 = 6'h06;
    localparam logic [5:0] VN_SHARE7 = 6'h07;
    localparam logic [5:0] VN_SHARE8 = 6'h08;
    localparam logic [5:0] VN_SHARE9 = 6'h09;
    localparam logic [5:0] VN_UART_BASE = 6'h0f;
    localparam logic [5:0] VN_TA0 = 6'h15;
    localparam logic [5:0] VN_TB0 = 6'h1a;
    localparam logic [5:0] VN_SHARE43 = 6'h2b;
    localparam logic [5:0] VN_SHARE46 = 6'h2e;
    localparam logic [5:0] VN_SHARE49 = 6'h31;
    localparam logic [5:0] VN_I2C = 6'h3b;
    localparam logic [5:0] VN_SCLSDA = 6'h3c;

    // ----------------------------------------------------------------
    // Source-select bit positions within each register
    // ----------------------------------------------------------------
    localparam int SEL_A_6 = 6;
    localparam int SEL_A_7 = 7;
    localparam int SEL_B_22 = 2;
    localparam int SEL_B_23 = 3;
    localparam int SEL_B_24 = 4;
    localparam int SEL_B_25 = 5;
    localparam int SEL_B_26 = 6;
    localparam int SEL_B_27 = 7;
    localparam int SEL_C_33 = 3;
    localparam int SEL_C_34 = 4;
    localparam int SEL_C_35 = 5;
    localparam int SEL_C_36 = 6;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        FETCH_LOW  = 3'b001,
        FETCH_HIGH = 3'b010,
        FETCH_IDLE = 3'b100
    } fetch_state_e;

    typedef struct packed {
        logic undef_op;
        logic overflow;
        logic break_op;
        logic addr_match;
        logic single_step;
        logic debug_break;
        logic nmi;
        logic sw_trap;
        logic [5:0] sw_num;
    } trap_req_s;

    typedef struct packed {
        logic watchdog;
        logic osc_detect;
        logic volt_mon1;
        logic volt_mon2;
    } sysmon_req_s;

    typedef struct packed {
        logic [7:0] sel_a;
        logic [7:0] sel_b;
        logic [7:0] sel_c;
    } source_select_s;
endpackage

/* verification/vector_memory_model.sv */
/*
 * Behavioural vector memory on the fetch side of the dispatch block.
 * Assumes mem_addr is held until mem_rvalid and moves on the next edge.
 */
`timescale 1ns/1ps
`default_nettype none
module vector_memory_model
    import vector_dispatch_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mem_req,
    input wire logic [19:0] mem_addr,
    input wire logic [1:0] lat,
    input wire logic break_ff,
    output logic [7:0] mem_rdata,
    output logic mem_rvalid
);
    logic [1:0] wait_cnt;

    // Each vector holds low, middle, a zero nibble over the upper nibble, then a zero byte.
    function automatic logic [7:0] image(input logic [19:0] a);
        case (a[1:0])
            2'h0: image = a[9:2];
            2'h1: image = a[17:10] ^ 8'ha5;
            2'h2: image = {4'h0, a[5:2]};
            default: image = 8'h00;
        endcase
    endfunction

    // The data lines toggle between answers so a stale byte is never mistaken for a fresh one.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt <= 2'h0;
            mem_rvalid <= 1'h0;
            mem_rdata <= 8'h5a;
        end else begin
            mem_rvalid <= 1'h0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_rvalid) begin
                if (wait_cnt == 2'h0) begin
                    mem_rvalid <= 1'h1;
                    mem_rdata <= (break_ff && mem_addr == BREAK_PROBE) ? BREAK_REDIRECT : image(mem_addr);
                    wait_cnt <= lat;
                end else begin
                    wait_cnt <= wait_cnt - 2'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* verification/interrupt_vector_dispatch_tb_top.sv */
/*
 * Self-checking bench for the vector dispatch block: fixed, redirected,
 * software and peripheral vectors against a behavioural vector memory.
 * Assumes the package, the design and the memory model compile first.
 */
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_dispatch_tb_top;
    import vector_dispatch_pkg::*;
    logic clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1, accept = 1'h0, reset_fetch = 1'h0, global_enable = 1'h0;
    logic ext_request_pin_7 = 1'h0, ext_request_pin_6 = 1'h0, ext_request_pin_5 = 1'h0, ext_request_pin_4 = 1'h0;
    logic ext_request_pin_3 = 1'h0, clocked_serial_3 = 1'h0, clocked_serial_4 = 1'h0;
    logic i2c_iface = 1'h0, scl_sda = 1'h0, break_ff = 1'h0;
    logic [4:0] timer_a = '0;
    logic [5:0] timer_b = '0;
    logic [7:0] uart_startstop = '0, uart_tx = '0, uart_rx = '0, uart_nack = '0, uart_ack = '0, uart_i2c_mode = '0;
    logic [1:0] consumer_control_link = '0, rtc_event = '0, remote_rx = '0, lat = '0;
    logic [19:0] vector_table_base = '0, base_v = '0, v;
    trap_req_s traps = '0, tr;
    sysmon_req_s sysmon = '0;
    source_select_s source_select = '0, sel;
    logic [7:0] mem_rdata;
    logic mem_rvalid, mem_req, pc_load, high_word_read, hw_request, busy;
    logic [19:0] mem_addr, pc;
    logic [5:0] hw_vector;
    logic [6:0] e;
    int err_count = 0, checks = 0, k, it;

    interrupt_vector_dispatch u_interrupt_vector_dispatch (
        .clk, .rst_n, .clk_en, .accept, .reset_fetch, .traps, .sysmon, .global_enable, .vector_table_base,
        .source_select, .timer_a, .timer_b, .ext_request_pin_7, .ext_request_pin_6, .ext_request_pin_5,
        .ext_request_pin_4, .ext_request_pin_3, .clocked_serial_3, .clocked_serial_4, .uart_startstop,
        .uart_tx, .uart_rx, .uart_nack, .uart_ack, .uart_i2c_mode, .consumer_control_link, .rtc_event,
        .remote_rx, .i2c_iface, .scl_sda, .mem_rdata, .mem_rvalid, .mem_req, .mem_addr, .pc, .pc_load,
        .high_word_read, .hw_vector, .hw_request, .busy
    );
    vector_memory_model u_vector_memory_model (
        .clk, .rst_n, .mem_req, .mem_addr, .lat, .break_ff, .mem_rdata, .mem_rvalid
    );

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic test_done();
        if (err_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Routine address that the memory model stores in a vector at a four-byte aligned address.
    function automatic logic [19:0] mpc(input logic [19:0] a);
        return {a[5:2], a[17:10] ^ 8'ha5, a[9:2]};
    endfunction

    // Sparse activity keeps a single source winning often enough to see each slot.
    function automatic logic [7:0] sp();
        return (it == 0) ? 8'h00 : 8'($urandom & $urandom & $urandom);
    endfunction

    function automatic logic [6:0] exp_hw();
        logic [63:0] m;
        logic [7:0] t;
        logic [7:0] r;
        logic [5:0] w;
        m = '0;
        w = '0;
        t = (uart_i2c_mode & uart_nack) | (~uart_i2c_mode & uart_tx);
        r = (uart_i2c_mode & uart_ack) | (~uart_i2c_mode & uart_rx);
        m[5:2] = {timer_b[5], ext_request_pin_3, ext_request_pin_6, ext_request_pin_7};
        m[6] = source_select.sel_b[SEL_B_27] ? uart_startstop[1] : timer_b[4];
        m[7] = source_select.sel_b[SEL_B_26] ? uart_startstop[0] : timer_b[3];
        m[8] = source_select.sel_a[SEL_A_7] ? ext_request_pin_5 : clocked_serial_4;
        m[9] = source_select.sel_a[SEL_A_6] ? ext_request_pin_4 : clocked_serial_3;
        m[10] = uart_startstop[2];
        m[20:15] = {r[1], t[1], r[0], t[0], r[2], t[2]};
        m[28:21] = {timer_b[2:0], timer_a};
        m[43] = source_select.sel_c[SEL_C_33] ? consumer_control_link[0] : uart_startstop[5];
        m[44] = source_select.sel_c[SEL_C_34] ? consumer_control_link[1] : t[5];
        m[46] = source_select.sel_c[SEL_C_35] ? rtc_event[0] : uart_startstop[6];
        m[47] = source_select.sel_c[SEL_C_36] ? rtc_event[1] : t[6];
        m[49] = source_select.sel_b[SEL_B_24] ? remote_rx[0] : uart_startstop[7];
        m[50] = source_select.sel_b[SEL_B_25] ? remote_rx[1] : t[7];
        m[45] = r[5];
        m[48] = r[6];
        m[51] = r[7];
        m[59] = source_select.sel_b[SEL_B_22] & i2c_iface;
        m[60] = source_select.sel_b[SEL_B_23] & scl_sda;
        for (int i = 63; i >= 0; i--) if (m[i]) w = 6'(i);
        return {(|m) & global_enable, w};
    endfunction

    // A poke offers a second request mid-fetch; it must be ignored while busy.
    task automatic fetch(input logic [19:0] first_exp, input logic [19:0] vec, input int hwx, input bit poke);
        int n;
        int hw;
        logic [19:0] first;
        logic seen;
        hw = 0;
        seen = 1'h0;
        first = '0;
        lat <= 2'($urandom);
        @(posedge clk);
        accept <= 1'h1;
        @(posedge clk);
        accept <= 1'h0;
        for (n = 0; n < 300; n++) begin
            @(posedge clk);
            #1;
            if (mem_req === 1'h1 && !seen) begin
                first = mem_addr;
                seen = 1'h1;
            end
            hw += int'(high_word_read === 1'h1);
            if (poke && n == 2) reset_fetch <= 1'h1;
            accept <= poke && n == 2;
            if (pc_load === 1'h1) break;
        end
        if (n == 300) begin
            chk("fetch_done", 20'h1, 20'h0);
            test_done();
        end
        chk("first_addr", first_exp, first);
        chk("pc", mpc(vec), pc);
        chk("busy", 20'h0, 20'(busy));
        if (hwx < 2) chk("high_word_read", 20'(hwx), 20'(hw != 0));
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'hb0e7a7f9));
        repeat (10) @(posedge clk);
        #1;
        chk("reset_pc", 20'h0, pc);
        chk("reset_busy", 20'h0, {busy, mem_req, pc_load, hw_request});
        @(posedge clk);
        rst_n <= 1'h1;
        for (k = 0; k < 14; k++) begin
            tr = '0;
            sysmon <= sysmon_req_s'((k >= 2 && k <= 5) ? 4'h1 << (k - 2) : 4'h0);
            reset_fetch <= (k == 0 || k == 13);
            case (k)
                0: v = FIX_RESET;
                1: begin tr.nmi = 1'h1; v = FIX_NMI; end
                2, 3, 4, 5: v = FIX_SYSMON;
                // Only a development tool raises the next two; the bench stands in for one.
                6: begin tr.debug_break = 1'h1; v = FIX_DEBUG; end
                7: begin tr.single_step = 1'h1; v = FIX_STEP; end
                8: begin tr.addr_match = 1'h1; v = FIX_ADDR_MATCH; end
                9: begin tr.break_op = 1'h1; v = FIX_BREAK; end
                10: begin tr.overflow = 1'h1; v = FIX_OVFL; end
                11: begin tr.undef_op = 1'h1; v = FIX_UNDEF; end
                12: begin tr.break_op = 1'h1; tr.single_step = 1'h1; v = FIX_STEP; end
                default: begin tr = '1; v = FIX_RESET; end
            endcase
            traps <= tr;
            fetch((k == 9) ? BREAK_PROBE : v, v, 1, k == 1);
        end
        traps <= '0;
        sysmon <= '0;
        reset_fetch <= 1'h0;
        for (k = 0; k < 14; k++) begin
            tr = '0;
            tr.break_op = (k == 0);
            tr.sw_trap = (k != 0);
            tr.sw_num = (k == 1) ? 6'h00 : (k == 2) ? 6'h3f : 6'($urandom);
            base_v = 20'($urandom) & 20'hffffc;
            vector_table_base <= base_v;
            break_ff <= (k == 0);
            traps <= tr;
            v = (k == 0) ? BREAK_PROBE : base_v + 20'({tr.sw_num, 2'h0});
            fetch(v, (k == 0) ? base_v : v, (k == 0) ? 2 : 0, 1'h0);
        end
        traps <= '0;
        break_ff <= 1'h0;
        for (it = 0; it < 300; it++) begin
            @(posedge clk);
            sel = source_select_s'($urandom);
            sel.sel_a[SEL_A_7] = sel.sel_a[SEL_A_6];
            source_select <= sel;
            global_enable <= (it % 3 != 1);
            {ext_request_pin_7, ext_request_pin_6, ext_request_pin_5, ext_request_pin_4} <= 4'(sp());
            {ext_request_pin_3, clocked_serial_3, clocked_serial_4, i2c_iface, scl_sda} <= 5'(sp());
            timer_a <= 5'(sp());
            timer_b <= 6'(sp());
            uart_startstop <= sp();
            uart_tx <= sp();
            uart_rx <= sp();
            uart_nack <= sp();
            uart_ack <= sp();
            uart_i2c_mode <= 8'($urandom);
            {consumer_control_link, rtc_event, remote_rx} <= 6'(sp());
            repeat (2) @(posedge clk);
            #1;
            e = exp_hw();
            chk("hw_request", 20'(e[6]), 20'(hw_request));
            if (e[6]) chk("hw_vector", 20'(e[5:0]), 20'(hw_vector));
            if (e[6] && it % 5 == 0) fetch(base_v + 20'({e[5:0], 2'h0}), base_v + 20'({e[5:0], 2'h0}), 0, 1'h0);
        end
        test_done();
    end
endmodule
`default_nettype wire
